/* pmi_pkg.sv */
package pmi_pkg;

  // Core clock
  localparam int CLK_HZ            = 125_000_000;
  localparam int CLK_PER_MS        = CLK_HZ / 1000;

  // Management clock spacing kept by the station; the edge minimum spans twenty core cycles
  localparam int MDC_MIN_EDGE_NS   = 160;
  localparam int MDC_MIN_CYCLE_NS  = 400;
  localparam int MDC_MIN_EDGE_CYC  = (MDC_MIN_EDGE_NS * CLK_PER_MS) / 1_000_000;

  // Late energy-detect pulse
  localparam int EDET_DELAY_MS     = 1000;
  localparam int EDET_PULSE_MS     = 256;
  localparam int EDET_DELAY_CYC    = EDET_DELAY_MS * CLK_PER_MS;
  localparam int EDET_PULSE_CYC    = EDET_PULSE_MS * CLK_PER_MS;

  // Register indices on the management port
  localparam logic [4:0] REG_STD_LAST   = 5'h06;
  localparam logic [4:0] REG_VND_FIRST  = 5'h10;
  localparam logic [4:0] REG_BASIC_STAT = 5'h01;
  localparam logic [4:0] REG_AN_EXP     = 5'h06;
  localparam logic [4:0] REG_MODE_CTRL  = 5'h11;
  localparam logic [4:0] REG_IRQ_FLAGS  = 5'h1D;
  localparam logic [4:0] REG_IRQ_MASK   = 5'h1E;

  // Field positions
  localparam int SRC_LSB           = 1;
  localparam int SRC_MSB           = 8;
  localparam int MODE_EDET_BIT     = 1;
  localparam int MODE_ALT_BIT      = 6;

  // Source vector index (register bit minus one)
  localparam int SRC_N             = 8;
  localparam int SRC_PAGE          = 0;
  localparam int SRC_PDF           = 1;
  localparam int SRC_ACK           = 2;
  localparam int SRC_LINK_DOWN     = 3;
  localparam int SRC_RFAULT        = 4;
  localparam int SRC_AN_DONE       = 5;
  localparam int SRC_EDET          = 6;
  localparam int SRC_WAKE          = 7;

  // Reset values
  localparam logic [7:0] FLAGS_RST = 8'h40;
  localparam logic [7:0] MASK_RST  = 8'h00;
  localparam logic       ALT_RST   = 1'b0;
  localparam logic [7:0] LEVEL_RST = 8'h40;

  // Management frame codes
  localparam logic [1:0] OP_READ   = 2'h2;
  localparam logic [1:0] OP_WRITE  = 2'h1;

  // Interrupt pin routing
  localparam logic [1:0] ROUTE_TXER = 2'h0;
  localparam logic [1:0] ROUTE_IND1 = 2'h1;
  localparam logic [1:0] ROUTE_IND2 = 2'h2;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } pmi_req_s;

  typedef struct packed {
    logic [3:0] wake;
    logic       edet;
    logic       an_done;
    logic       rfault;
    logic       link_up;
    logic       ack;
    logic       pdf;
    logic       page;
    logic       an_restart;
  } pmi_src_s;

  typedef enum logic [2:0] {
    FR_HUNT, FR_START, FR_OP, FR_PHY, FR_REG, FR_TA, FR_RDATA, FR_WDATA
  } pmi_frame_e;

  typedef enum logic [1:0] {
    EP_IDLE, EP_ARMED, EP_WAIT, EP_PULSE
  } pmi_epulse_e;

endpackage

/* pmi_mdio_frame.sv */
`timescale 1ns/1ps
module pmi_mdio_frame
  import pmi_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic nrst,
  // Management pins
  input  wire logic mdc,
  input  wire logic mdio_in,
  output logic      mdio_out,
  output logic      mdio_oe_n,
  // Register side
  input  wire logic [4:0]  phy_addr,
  input  wire logic [15:0] rd_data,
  output pmi_req_s         req
);

  logic       mdc_s1, mdc_s2, mdc_s3;
  logic       mdio_s1, mdio_s2;
  pmi_frame_e state;
  logic [3:0] cnt;
  logic [15:0] sh;
  logic [1:0] op;
  logic       seen_one;
  logic       for_us;

  // MDC is slow against the core clock, so edges are found by oversampling
  wire mdc_rise = mdc_s2 & ~mdc_s3;
  wire bit_in   = mdio_s2;
  wire last4    = (cnt == 4'h4);

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      {mdc_s1, mdc_s2, mdc_s3} <= 3'h0;
      {mdio_s1, mdio_s2}       <= 2'h3;
    end
    else
    begin
      {mdc_s1, mdc_s2, mdc_s3} <= {mdc, mdc_s1, mdc_s2};
      {mdio_s1, mdio_s2}       <= {mdio_in, mdio_s1};
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      state     <= FR_HUNT;
      cnt       <= 4'h0;
      sh        <= 16'h0000;
      op        <= 2'h0;
      seen_one  <= 1'b0;
      for_us    <= 1'b0;
      req       <= '0;
      mdio_out  <= 1'b1;
      mdio_oe_n <= 1'b1;
    end
    else
    begin
      req.rd <= 1'b0;
      req.wr <= 1'b0;
      if (req.rd)
        sh <= rd_data;
      if (mdc_rise)
      begin
        cnt <= cnt + 4'h1;
        case (state)
          FR_HUNT:
          begin
            seen_one <= bit_in;
            if (seen_one && !bit_in)
              state <= FR_START;
          end
          FR_START:
          begin
            cnt      <= 4'h0;
            seen_one <= 1'b0;
            state    <= bit_in ? FR_OP : FR_HUNT;
          end
          FR_OP:
          begin
            op <= {op[0], bit_in};
            if (cnt[0])
            begin
              cnt   <= 4'h0;
              state <= FR_PHY;
            end
          end
          FR_PHY:
          begin
            sh <= {sh[14:0], bit_in};
            if (last4)
            begin
              cnt    <= 4'h0;
              for_us <= ({sh[3:0], bit_in} == phy_addr);
              state  <= FR_REG;
            end
          end
          FR_REG:
          begin
            sh <= {sh[14:0], bit_in};
            if (last4)
            begin
              cnt      <= 4'h0;
              req.addr <= {sh[3:0], bit_in};
              req.rd   <= for_us && (op == OP_READ);
              state    <= FR_TA;
            end
          end
          FR_TA:
          begin
            if (for_us && op == OP_READ)
            begin
              mdio_oe_n <= 1'b0;
              mdio_out  <= cnt[0] ? sh[15] : 1'b0;
            end
            if (cnt[0])
            begin
              cnt   <= 4'h0;
              state <= (for_us && op == OP_READ) ? FR_RDATA :
                       (for_us && op == OP_WRITE) ? FR_WDATA : FR_HUNT;
            end
          end
          FR_RDATA:
          begin
            sh       <= {sh[14:0], 1'b0};
            mdio_out <= sh[14];
            if (cnt == 4'hF)
            begin
              mdio_oe_n <= 1'b1;
              mdio_out  <= 1'b1;
              state     <= FR_HUNT;
            end
          end
          FR_WDATA:
          begin
            sh <= {sh[14:0], bit_in};
            if (cnt == 4'hF)
            begin
              req.wdata <= {sh[14:0], bit_in};
              req.wr    <= 1'b1;
              state     <= FR_HUNT;
            end
          end
          default:
            state <= FR_HUNT;
        endcase
      end
    end
  end

endmodule

/* pmi_edet_pulse.sv */
`timescale 1ns/1ps
module pmi_edet_pulse
  import pmi_pkg::*;
#(
  parameter int DELAY_CYC = EDET_DELAY_CYC,
  parameter int PULSE_CYC = EDET_PULSE_CYC
)
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic nrst,
  // Control
  input  wire logic arm,
  input  wire logic disarm,
  input  wire logic edet_fall,
  output logic      pulse
);

  localparam int CW = $clog2(DELAY_CYC > PULSE_CYC ? DELAY_CYC + 1 : PULSE_CYC + 1);

  pmi_epulse_e   state;
  logic [CW-1:0] cnt;

  wire cnt_done = (cnt == '0);

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      state <= EP_IDLE;
      cnt   <= '0;
      pulse <= 1'b0;
    end
    else if (disarm)
    begin
      // Clearing the mask cancels a pending late pulse
      state <= EP_IDLE;
      pulse <= 1'b0;
    end
    else
    begin
      case (state)
        EP_IDLE:
          if (arm)
            state <= EP_ARMED;
        EP_ARMED:
          if (edet_fall)
          begin
            cnt   <= CW'(DELAY_CYC - 1);
            state <= EP_WAIT;
          end
        EP_WAIT:
          if (cnt_done)
          begin
            cnt   <= CW'(PULSE_CYC - 1);
            pulse <= 1'b1;
            state <= EP_PULSE;
          end
          else
            cnt <= cnt - CW'(1);
        EP_PULSE:
          if (cnt_done)
          begin
            pulse <= 1'b0;
            state <= EP_IDLE;
          end
          else
            cnt <= cnt - CW'(1);
        default:
          state <= EP_IDLE;
      endcase
    end
  end

endmodule

/* pmi_irq_logic.sv */
`timescale 1ns/1ps
module pmi_irq_logic
  import pmi_pkg::*;
#(
  parameter int EDET_DELAY = EDET_DELAY_CYC,
  parameter int EDET_PULSE = EDET_PULSE_CYC
)
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Management pins
  input  wire logic        mdc,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe_n,
  input  wire logic [4:0]  phy_addr,
  // Source conditions
  input  wire pmi_src_s    src,
  // Other management registers
  input  wire logic [15:0] ext_rd_data,
  output logic [4:0]       ext_addr,
  output logic             ext_rd,
  output logic             ext_wr,
  output logic [15:0]      ext_wr_data,
  // Interrupt outputs
  input  wire logic [1:0]  irq_route,
  output logic             irq_out_low,
  output logic             irq_on_txer_low,
  output logic             irq_on_ind1_low,
  output logic             irq_on_ind2_low
);

  function automatic logic reg_mapped(input logic [4:0] a);
    reg_mapped = (a <= REG_STD_LAST) || (a >= REG_VND_FIRST);
  endfunction

  pmi_req_s        req;
  pmi_src_s        src_s1;
  pmi_src_s        src_s2;
  logic [SRC_N-1:0] lvl_q;
  logic            restart_q;
  logic [SRC_N-1:0] flags;
  logic [SRC_N-1:0] mask;
  logic            alt_mode;
  logic            edet_pulse;
  logic [15:0]     rd_data;

  // Source levels, link down as the inverse of link status
  wire [SRC_N-1:0] lvl = {
    |src_s2.wake,
    src_s2.edet,
    src_s2.an_done,
    src_s2.rfault,
    ~src_s2.link_up,
    src_s2.ack,
    src_s2.pdf,
    src_s2.page
  };

  wire [SRC_N-1:0] rise_ev  = lvl & ~lvl_q;
  wire [SRC_N-1:0] fall_ev  = ~lvl & lvl_q;
  wire             restart  = src_s2.an_restart & ~restart_q;
  wire             link_dn  = rise_ev[SRC_LINK_DOWN];

  // Register access decode
  wire rd29 = req.rd && (req.addr == REG_IRQ_FLAGS);
  wire rd1  = req.rd && (req.addr == REG_BASIC_STAT);
  wire rd6  = req.rd && (req.addr == REG_AN_EXP);
  wire wr29 = req.wr && (req.addr == REG_IRQ_FLAGS);
  wire wr30 = req.wr && (req.addr == REG_IRQ_MASK);
  wire wr17 = req.wr && (req.addr == REG_MODE_CTRL);

  wire [SRC_N-1:0] wr_flag_ones = req.wdata[SRC_MSB:SRC_LSB];
  wire [SRC_N-1:0] next_mask    = wr30 ? req.wdata[SRC_MSB:SRC_LSB] : mask;

  // Primary mode release events per source
  wire [SRC_N-1:0] rel_edge = fall_ev & ~(SRC_N'(1) << SRC_LINK_DOWN);
  wire             rel_an   = rd6 | restart | link_dn;
  wire [SRC_N-1:0] rel_extra = {
    1'b0, 1'b0, 1'b0,
    rd1,
    rd1,
    1'b0,
    rel_an,
    rel_an
  };
  wire [SRC_N-1:0] rel_pri = rel_edge | rel_extra | {SRC_N{rd29}};

  // Alternate mode: a written 1 clears only if the source is idle now
  wire [SRC_N-1:0] rel_alt = {SRC_N{wr29}} & wr_flag_ones & ~lvl;

  wire [SRC_N-1:0] clr_ev    = alt_mode ? rel_alt : rel_pri;
  // New event wins against a same-cycle clear
  wire [SRC_N-1:0] next_flags = (flags & ~clr_ev) | rise_ev;

  // Energy detect released while still high arms the late pulse
  wire edet_arm = mask[SRC_EDET] & flags[SRC_EDET] & ~next_flags[SRC_EDET]
                  & lvl[SRC_EDET];
  wire edet_off = ~next_mask[SRC_EDET];

  // Output stays low while any enabled flag is set
  wire irq_req  = |(flags & mask) | edet_pulse;

  // Read data selection
  wire [15:0] flag_word = 16'(flags) << SRC_LSB;
  wire [15:0] mask_word = 16'(mask) << SRC_LSB;
  wire [15:0] mode_word = (ext_rd_data
                           & ~(16'h0001 << MODE_ALT_BIT)
                           & ~(16'h0001 << MODE_EDET_BIT))
                          | (16'(alt_mode) << MODE_ALT_BIT)
                          | (16'(src_s2.edet) << MODE_EDET_BIT);

  always_comb
  begin
    case (req.addr)
      REG_IRQ_FLAGS: rd_data = flag_word;
      REG_IRQ_MASK:  rd_data = mask_word;
      REG_MODE_CTRL: rd_data = mode_word;
      default:       rd_data = reg_mapped(req.addr) ? ext_rd_data : 16'h0000;
    endcase
  end

  pmi_mdio_frame u_frame (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .mdc       (mdc),
    .mdio_in   (mdio_in),
    .mdio_out  (mdio_out),
    .mdio_oe_n (mdio_oe_n),
    .phy_addr  (phy_addr),
    .rd_data   (rd_data),
    .req       (req)
  );

  pmi_edet_pulse #(
    .DELAY_CYC (EDET_DELAY),
    .PULSE_CYC (EDET_PULSE)
  ) u_edet (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .arm       (edet_arm),
    .disarm    (edet_off),
    .edet_fall (fall_ev[SRC_EDET]),
    .pulse     (edet_pulse)
  );

  // Source pins are asynchronous; energy detect starts high during acquisition
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      // Link idles up so no false link-down edge follows reset
      src_s1 <= '{edet: 1'b1, link_up: 1'b1, default: 1'b0};
      src_s2 <= '{edet: 1'b1, link_up: 1'b1, default: 1'b0};
    end
    else
    begin
      src_s1 <= src;
      src_s2 <= src_s1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      lvl_q     <= LEVEL_RST;
      restart_q <= 1'b0;
    end
    else
    begin
      lvl_q     <= lvl;
      restart_q <= src_s2.an_restart;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      flags    <= FLAGS_RST;
      mask     <= MASK_RST;
      alt_mode <= ALT_RST;
    end
    else
    begin
      flags <= next_flags;
      mask  <= next_mask;
      if (wr17)
        alt_mode <= req.wdata[MODE_ALT_BIT];
    end
  end

  // Pass-through access: reads of all mapped registers, writes of all but flags and mask
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      ext_addr    <= 5'h00;
      ext_rd      <= 1'b0;
      ext_wr      <= 1'b0;
      ext_wr_data <= 16'h0000;
    end
    else
    begin
      ext_addr    <= req.addr;
      ext_rd      <= req.rd && reg_mapped(req.addr);
      ext_wr      <= req.wr && reg_mapped(req.addr)
                     && (req.addr != REG_IRQ_FLAGS) && (req.addr != REG_IRQ_MASK);
      ext_wr_data <= req.wdata;
    end
  end

  // Unselected pins idle high
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      irq_out_low     <= 1'b1;
      irq_on_txer_low <= 1'b1;
      irq_on_ind1_low <= 1'b1;
      irq_on_ind2_low <= 1'b1;
    end
    else
    begin
      irq_out_low     <= ~irq_req;
      irq_on_txer_low <= ~(irq_req && irq_route == ROUTE_TXER);
      irq_on_ind1_low <= ~(irq_req && irq_route == ROUTE_IND1);
      irq_on_ind2_low <= ~(irq_req && irq_route == ROUTE_IND2);
    end
  end

endmodule

/* pmi_irq_logic_assertions.sv */
`timescale 1ns/1ps
module pmi_chk
  import pmi_pkg::*;
#(
  parameter int EDET_DELAY = 40,
  parameter int EDET_PULSE = 20
)
(
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        nrst,
  // Management pins
  input wire logic        mdc,
  input wire logic        mdio_in,
  input wire logic        mdio_out,
  input wire logic        mdio_oe_n,
  input wire logic [4:0]  phy_addr,
  // Sources and other registers
  input wire pmi_src_s    src,
  input wire logic [15:0] ext_rd_data,
  input wire logic [4:0]  ext_addr,
  input wire logic        ext_rd,
  input wire logic        ext_wr,
  input wire logic [15:0] ext_wr_data,
  // Interrupt outputs
  input wire logic [1:0]  irq_route,
  input wire logic        irq_out_low,
  input wire logic        irq_on_txer_low,
  input wire logic        irq_on_ind1_low,
  input wire logic        irq_on_ind2_low
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  wire mapped   = (ext_addr <= REG_STD_LAST) || (ext_addr >= REG_VND_FIRST);

  // Copies may be registered, so only judged once route and source held a cycle
  a_txer_copy: assert property ($stable(irq_route) && $stable(irq_out_low) |->
    irq_on_txer_low == ((irq_route == ROUTE_TXER) ? irq_out_low : 1'b1))
    else $error("txer copy wrong");
  a_ind1_copy: assert property ($stable(irq_route) && $stable(irq_out_low) |->
    irq_on_ind1_low == ((irq_route == ROUTE_IND1) ? irq_out_low : 1'b1))
    else $error("indicator one copy wrong");
  a_ind2_copy: assert property ($stable(irq_route) && $stable(irq_out_low) |->
    irq_on_ind2_low == ((irq_route == ROUTE_IND2) ? irq_out_low : 1'b1))
    else $error("indicator two copy wrong");
  a_reset_idle: assert property ($rose(nrst) |-> mdio_oe_n && irq_out_low)
    else $error("outputs not idle after reset");
  a_ta_zero: assert property ($fell(mdio_oe_n) |-> !mdio_out && mdc)
    else $error("turnaround drive wrong");
  a_data_on_rise: assert property (!mdio_oe_n && $changed(mdio_out) |-> mdc)
    else $error("read data moved while clock low");
  a_rd_pulse: assert property (ext_rd |=> !ext_rd)
    else $error("read strobe longer than one cycle");
  a_mapped_only: assert property ((ext_rd || ext_wr) |-> mapped)
    else $error("strobe for unmapped register");
  a_wr_local: assert property (ext_wr |->
    ext_addr != REG_IRQ_FLAGS && ext_addr != REG_IRQ_MASK)
    else $error("interrupt register write forwarded");

  c_irq: cover property ($fell(irq_out_low));
  c_read: cover property ($fell(mdio_oe_n));
  c_write: cover property (ext_wr);
endmodule

/* pmi_station.sv */
`timescale 1ns/1ps
module pmi_station
  import pmi_pkg::*;
#(
  parameter logic [4:0] PHY     = 5'h03,
  parameter int         HALF_NS = 200
)
(
  // Management pins
  output logic        mdc,
  output logic        dat,
  output logic        drive,
  input  wire logic   mdio,
  // Read result
  output logic        rd_done,
  output logic [15:0] rd_val
);
  initial
  begin
    mdc = 1'b0;
    dat = 1'b1;
    drive = 1'b0;
    rd_done = 1'b0;
    rd_val = 16'h0000;
  end

  // Half period above the edge minimum, full period equal to the cycle minimum; clock idles low between frames
  task automatic send(input logic v);
    drive = 1'b1;
    dat = v;
    #(HALF_NS) mdc = 1'b1;
    #(HALF_NS) mdc = 1'b0;
  endtask

  task automatic xfer(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd);
    logic [14:0] hdr;
    logic [15:0] rv;
    hdr = {1'b1, 2'b01, op, PHY, ra};
    rv = 16'h0000;
    for (int i = 14; i >= 0; i--)
      send(hdr[i]);
    if (op == OP_WRITE)
    begin
      send(1'b1);
      send(1'b0);
      for (int i = 15; i >= 0; i--)
        send(wd[i]);
    end
    else
    begin
      // Released line floats to the pull-up until the device takes it
      drive = 1'b0;
      repeat (2)
      begin
        #(HALF_NS) mdc = 1'b1;
        #(HALF_NS) mdc = 1'b0;
      end
      for (int i = 0; i < 16; i++)
      begin
        #(HALF_NS) rv = {rv[14:0], mdio};
        mdc = 1'b1;
        #(HALF_NS) mdc = 1'b0;
      end
      rd_val = rv;
      rd_done = 1'b1;
      #8 rd_done = 1'b0;
    end
    drive = 1'b0;
  endtask
endmodule

/* tb_pmi_irq_logic.sv */
`timescale 1ns/1ps
module tb_pmi_irq_logic
  import pmi_pkg::*;
;
  localparam int EDET_DELAY = 40;
  localparam int EDET_PULSE = 20;

  logic        core_clk;
  logic        nrst;
  logic [1:0]  irq_route;
  pmi_src_s    src;
  logic        mdc;
  logic        st_dat;
  logic        st_drive;
  logic        mdio_out;
  logic        mdio_oe_n;
  logic        irq_out_low;
  logic        rd_done;
  logic [15:0] rd_val;
  logic [15:0] cnt;
  logic [31:0] rng;
  logic [15:0] exp_q[$];
  int          n_mismatch;
  int          check_count;

  // Pull-up holds the line high when nobody drives it
  wire mdio_w = !mdio_oe_n ? mdio_out : (st_drive ? st_dat : 1'b1);

  pmi_irq_logic #(.EDET_DELAY(EDET_DELAY), .EDET_PULSE(EDET_PULSE)) pmi_irq_logic_i (
    .core_clk(core_clk), .nrst(nrst), .mdc(mdc), .mdio_in(mdio_w),
    .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .phy_addr(5'h03), .src(src),
    .ext_rd_data(16'h0000), .ext_addr(), .ext_rd(), .ext_wr(), .ext_wr_data(),
    .irq_route(irq_route), .irq_out_low(irq_out_low), .irq_on_txer_low(),
    .irq_on_ind1_low(), .irq_on_ind2_low());

  pmi_station pmi_station_i (.mdc(mdc), .dat(st_dat), .drive(st_drive), .mdio(mdio_w),
    .rd_done(rd_done), .rd_val(rd_val));

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] e);
    check_count++;
    if (seen !== e)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, e);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask

  task automatic wait_irq(input logic e);
    int i;
    i = 0;
    while (irq_out_low !== e && i < 40)
    begin
      tick();
      i++;
    end
    check({15'h0000, irq_out_low}, {15'h0000, e});
    if (i == 40)
      conclude();
  endtask

  task automatic rd(input logic [4:0] ra, input logic [15:0] e);
    exp_q.push_back(e);
    pmi_station_i.xfer(OP_READ, ra, 16'h0000);
  endtask

  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    pmi_station_i.xfer(OP_WRITE, ra, d);
  endtask

  task automatic set_src(input int k, input logic v);
    case (k)
      SRC_WAKE: src.wake[2] = v;
      SRC_EDET: src.edet = v;
      SRC_AN_DONE: src.an_done = v;
      SRC_RFAULT: src.rfault = v;
      SRC_LINK_DOWN: src.link_up = !v;
      SRC_ACK: src.ack = v;
      SRC_PDF: src.pdf = v;
      default: src.page = v;
    endcase
  endtask

  // Read results come back in request order
  always @(posedge rd_done)
  begin
    if (exp_q.size() == 0)
      check(rd_val, 16'hFFFF);
    else
      check(rd_val, exp_q.pop_front());
  end

  initial
  begin
    n_mismatch = 0;
    check_count = 0;
    rng = 32'h0000_0047;
    nrst = 1'b0;
    irq_route = 2'h0;
    src = '0;
    src.link_up = 1'b1;
    // Energy detect high as during acquisition at power-up
    src.edet = 1'b1;
    repeat (6) @(posedge core_clk);
    #1 nrst = 1'b1;
    repeat (4) tick();
    wait_irq(1'b1);
    rd(REG_IRQ_FLAGS, 16'h0080);
    rd(REG_IRQ_FLAGS, 16'h0000);
    src.edet = 1'b0;
    rd(REG_IRQ_MASK, 16'h0000);
    rd(REG_MODE_CTRL, 16'h0000);
    rd(5'h09, 16'h0000);
    wr(REG_IRQ_MASK, 16'h01FE);
    rd(REG_IRQ_MASK, 16'h01FE);
    for (int k = 0; k < SRC_N; k++)
    begin
      if (k == SRC_LINK_DOWN)
        continue;
      rng = xs(rng);
      irq_route = rng[1:0];
      set_src(k, 1'b1);
      wait_irq(1'b0);
      set_src(k, 1'b0);
      wait_irq(1'b1);
    end
    set_src(SRC_LINK_DOWN, 1'b1);
    wait_irq(1'b0);
    set_src(SRC_LINK_DOWN, 1'b0);
    repeat (12) tick();
    wait_irq(1'b0);
    rd(REG_BASIC_STAT, 16'h0000);
    wait_irq(1'b1);
    src.wake[2] = 1'b1;
    wait_irq(1'b0);
    rd(REG_IRQ_FLAGS, 16'h0100);
    wait_irq(1'b1);
    src.wake[2] = 1'b0;
    wr(REG_MODE_CTRL, 16'h0040);
    rd(REG_MODE_CTRL, 16'h0040);
    src.ack = 1'b1;
    src.pdf = 1'b1;
    wait_irq(1'b0);
    src.ack = 1'b0;
    repeat (12) tick();
    wait_irq(1'b0);
    wr(REG_IRQ_FLAGS, 16'h000C);
    rd(REG_IRQ_FLAGS, 16'h0004);
    wait_irq(1'b0);
    wr(REG_IRQ_MASK, 16'h0000);
    wait_irq(1'b1);
    src.pdf = 1'b0;
    wr(REG_IRQ_FLAGS, 16'h0004);
    rd(REG_IRQ_FLAGS, 16'h0000);
    wr(REG_MODE_CTRL, 16'h0000);
    wr(REG_IRQ_MASK, 16'h0006);
    src.pdf = 1'b1;
    wait_irq(1'b0);
    rd(REG_AN_EXP, 16'h0000);
    wait_irq(1'b1);
    src.page = 1'b1;
    wait_irq(1'b0);
    src.an_restart = 1'b1;
    wait_irq(1'b1);
    src.page = 1'b0;
    src.pdf = 1'b0;
    src.an_restart = 1'b0;
    wr(REG_IRQ_MASK, 16'h0080);
    src.edet = 1'b1;
    wait_irq(1'b0);
    rd(REG_IRQ_FLAGS, 16'h0080);
    wait_irq(1'b1);
    src.edet = 1'b0;
    cnt = 16'h0000;
    repeat (150)
    begin
      tick();
      if (irq_out_low === 1'b0)
        cnt++;
    end
    check(cnt, 16'(EDET_PULSE));
    wr(REG_IRQ_MASK, 16'h0000);
    repeat (10) tick();
    check(16'(exp_q.size()), 16'h0000);
    conclude();
  end
endmodule

bind pmi_irq_logic pmi_chk #(.EDET_DELAY(EDET_DELAY), .EDET_PULSE(EDET_PULSE)) pmi_chk_i (
  .core_clk, .nrst, .mdc, .mdio_in, .mdio_out, .mdio_oe_n, .phy_addr, .src, .ext_rd_data,
  .ext_addr, .ext_rd, .ext_wr, .ext_wr_data, .irq_route, .irq_out_low, .irq_on_txer_low,
  .irq_on_ind1_low, .irq_on_ind2_low);
